// file: rtl/gfs_map.svh
// Register map, field positions, reset values and timing values (clock in Hz, durations in us and ms) of the gas flow supervisor
`ifndef GFS_MAP_SVH
`define GFS_MAP_SVH
// Register byte offsets
`define GFS_REG_CTRL     8'h00
`define GFS_REG_FLOW     8'h04
`define GFS_REG_STATUS   8'h08
`define GFS_REG_LEDLAT   8'h0c
`define GFS_REG_PANEL    8'h10
`define GFS_REG_TANK1    8'h14
`define GFS_REG_TANK2    8'h18
`define GFS_REG_SEG      8'h1c
`define GFS_REG_BAR      8'h20
`define GFS_REG_ADC_SEL  8'h24
`define GFS_REG_ADC_DATA 8'h28
`define GFS_REG_LIMITS   8'h2c
// Control register fields
`define GFS_CTRL_PWR     0
`define GFS_CTRL_ESU_CUT 1
`define GFS_CTRL_ESU_CO  2
`define GFS_CTRL_INIT_OK 3
`define GFS_CTRL_SWFAULT 4
// Status register fields
`define GFS_ST_DOSE      0
`define GFS_ST_RAIL      1
`define GFS_ST_INTEG     2
`define GFS_ST_SUPV_OFF  3
`define GFS_ST_SCALE     4
`define GFS_ST_RUN       5
`define GFS_ST_TANKS     6
`define GFS_ST_PWR_ON    8
// Reset values
`define GFS_LEDLAT_RST   4'hf
`define GFS_LIMITS_RST   16'h0000
// Timing
`define GFS_CLK_HZ       20000000
`define GFS_POR_US       10
`define GFS_LAMP_MS      3000
`define GFS_BEEP_MS      100
`define GFS_FLASH_MS     250
`endif

// file: rtl/gfs_pkg.sv
// Types shared by the gas flow supervisor files
package gfs_pkg;
  typedef enum logic [1:0]
  {
    GFS_POR  = 2'b00,
    GFS_LAMP = 2'b01,
    GFS_RUN  = 2'b10
  } gfs_phase_t;
endpackage

// file: rtl/gfs_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module gfs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // Pins and synchronised copy
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff; // First stage, read only by second

  // Two flops in a row
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_ff  <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_ff  <= pin_in;
      sync_out <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// file: rtl/gfs_top.sv
// Gas flow orifice control and safety supervisor with Avalon-MM registers
//
// Contract
// [R1] Five binary-weighted orifices, any combination open
// [R2] Solenoids follow selected panel flow rate
// [R3] Beep on error or panel change
// [R4] Master switch feeds solenoids, cut on fault
// [R5] Two-stage reset holds controller after power-up
// [R6] Out-of-range flow: inhibit, alarm, flash code
// [R7] Dosage error latched until power cycle
// [R8] Supervisor checks integrity and unreported errors
// [R9] Strap disables supervisor for test mode
// [R10] Rail monitor trip latches shutdown
// [R11] Per-tank transducer detection inputs
// [R12] Tank bar graph only when transducer present (lamp test lights both bars regardless)
// [R13] Strap scales tank reading for 2000 psig
// [R14] Converter samples readable by controller
// [R15] Indicator latch bits are active low
// [R16] Knobs and buttons readable by controller
// [R17] Segment and bar drivers show readings, setpoint
// [R18] Cut and coag activation drive generator
// [R19] All LEDs lit three seconds after init
// [R20] Any latched fault closes every solenoid
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "gfs_map.svh"
module gfs_top
  import gfs_pkg::*;
#(
  parameter int POR_CYC  = (`GFS_CLK_HZ / 1000000) * `GFS_POR_US,
  parameter int LAMP_CYC = (`GFS_CLK_HZ / 1000) * `GFS_LAMP_MS,
  parameter int BEEP_CYC = (`GFS_CLK_HZ / 1000) * `GFS_BEEP_MS,
  parameter int FLSH_CYC = (`GFS_CLK_HZ / 1000) * `GFS_FLASH_MS
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  output var  logic [1:0]  avs_response,
  // Straps and monitor pins
  input  wire logic        supervisor_disable_strap,
  input  wire logic        tank_scale_strap,
  input  wire logic        rail5_fault,
  input  wire logic        rail12_fault,
  input  wire logic [1:0]  tank_detect,
  // Panel inputs
  input  wire logic [7:0]  panel_switches,
  // Handset and footswitch
  input  wire logic        act_cut,
  input  wire logic        act_coag,
  // Converter result
  input  wire logic [11:0] adc_sample,
  input  wire logic        adc_valid,
  output var  logic [2:0]  adc_channel,
  // Actuators
  output var  logic [4:0]  solenoid_on,
  output var  logic        solenoid_power,
  output var  logic        audio_enable,
  output var  logic        esu_cut,
  output var  logic        esu_coag,
  output var  logic        controller_run,
  // Panel outputs
  output var  logic [3:0]  led_n,
  output var  logic [7:0]  segment_data,
  output var  logic [7:0]  bar_tank1,
  output var  logic [7:0]  bar_tank2,
  output var  logic [7:0]  bar_setpoint,
  output var  logic        error_flash
);
  // Synchronised pins
  logic [15:0] pins_s;
  logic        sup_off, scale, r5, r12, cut_s, coag_s;
  logic [1:0]  tdet;
  logic [7:0]  sw_s;

  gfs_sync #(.W(16)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   ({supervisor_disable_strap, tank_scale_strap, rail5_fault, rail12_fault,
                tank_detect, act_cut, act_coag, panel_switches}),
    .sync_out (pins_s)
  );
  assign {sup_off, scale, r5, r12, tdet, cut_s, coag_s, sw_s} = pins_s;

  // Registers
  logic [4:0]  ctrl_ff;      // Power, ESU enables, init ok, sw fault
  logic [4:0]  flow_ff;      // Selected flow in half-LPM steps
  logic [3:0]  ledlat_ff;    // Active-low LED latch
  logic [7:0]  seg_ff;       // Segment code
  logic [7:0]  bar_ff;       // Setpoint bar
  logic [2:0]  adcsel_ff;    // Converter channel
  logic [11:0] adcdat_ff;    // Last sample
  logic [7:0]  lim_lo_ff;    // Lower flow limit, half LPM
  logic [7:0]  lim_hi_ff;    // Upper flow limit, half LPM
  logic [7:0]  tank1_ff, tank2_ff;
  logic [7:0]  sw_prev_ff;
  logic        dose_ff, rail_ff, integ_ff;
  logic        strap_ff, scale_ff;
  gfs_phase_t  phase_ff;
  logic [31:0] cnt_ff;
  logic [31:0] beep_ff;
  logic [31:0] flash_ff;
  logic        flash_ph_ff;
  logic        ack_ff;
  logic        fault;

  // Bus access strobes; one wait cycle, answer on second cycle
  logic req, wr;
  assign req = (avs_read | avs_write) & ~ack_ff;
  assign wr  = avs_write & ack_ff;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;

  // Acknowledge pulse after one wait state
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ack_ff <= 1'b0;
    else
      ack_ff <= req;
  end

  // Power-up sequence: hold, then lamp test, then run
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      phase_ff <= GFS_POR;
      cnt_ff   <= '0;
    end
    else
    begin
      unique case (phase_ff)
        GFS_POR:
        begin
          // Second reset stage holds the controller
          if (cnt_ff == 32'(POR_CYC - 1)) // R5
          begin
            phase_ff <= GFS_LAMP;
            cnt_ff   <= '0;
          end
          else
            cnt_ff <= cnt_ff + 32'h1;
        end
        GFS_LAMP:
        begin
          // Every LED on for the lamp test period
          if (cnt_ff == 32'(LAMP_CYC - 1)) // R19
          begin
            phase_ff <= GFS_RUN;
            cnt_ff   <= '0;
          end
          else
            cnt_ff <= cnt_ff + 32'h1;
        end
        GFS_RUN:
          cnt_ff <= cnt_ff;
      endcase
    end
  end
  assign controller_run = (phase_ff != GFS_POR); // R5

  // Straps caught at the end of the hold phase
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      strap_ff <= 1'b0;
      scale_ff <= 1'b0;
    end
    else if (phase_ff == GFS_POR)
    begin
      strap_ff <= sup_off; // R9
      scale_ff <= scale;   // R13
    end
  end

  // Control and data registers written by software
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_ff   <= '0;
      flow_ff   <= '0;
      ledlat_ff <= `GFS_LEDLAT_RST;
      seg_ff    <= '0;
      bar_ff    <= '0;
      adcsel_ff <= '0;
      {lim_hi_ff, lim_lo_ff} <= `GFS_LIMITS_RST;
      tank1_ff  <= '0;
      tank2_ff  <= '0;
    end
    else if (wr && avs_byteenable[0])
    begin
      unique case (avs_address)
        `GFS_REG_CTRL:    ctrl_ff   <= avs_writedata[4:0];
        `GFS_REG_FLOW:    flow_ff   <= avs_writedata[4:0]; // R2
        `GFS_REG_LEDLAT:  ledlat_ff <= avs_writedata[3:0]; // R15
        `GFS_REG_SEG:     seg_ff    <= avs_writedata[7:0]; // R17
        `GFS_REG_BAR:     bar_ff    <= avs_writedata[7:0]; // R17
        `GFS_REG_ADC_SEL: adcsel_ff <= avs_writedata[2:0]; // R14
        `GFS_REG_TANK1:   tank1_ff  <= avs_writedata[7:0];
        `GFS_REG_TANK2:   tank2_ff  <= avs_writedata[7:0];
        `GFS_REG_LIMITS:
        begin
          lim_lo_ff <= avs_writedata[7:0];
          if (avs_byteenable[1])
            lim_hi_ff <= avs_writedata[15:8];
        end
        default: ;
      endcase
    end
  end

  // Converter sample capture
  always_ff @(posedge core_clk)
  begin
    if (rst)
      adcdat_ff <= '0;
    else if (adc_valid)
      adcdat_ff <= adc_sample; // R14
  end
  assign adc_channel = adcsel_ff;

  // Supervisor compares selected flow against limits
  logic dose_bad;
  assign dose_bad = (phase_ff == GFS_RUN) && ctrl_ff[`GFS_CTRL_PWR]
                    && ((8'(flow_ff) < lim_lo_ff) || (8'(flow_ff) > lim_hi_ff));

  // Latched faults, cleared only by power cycle (reset)
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dose_ff  <= 1'b0;
      rail_ff  <= 1'b0;
      integ_ff <= 1'b0;
    end
    else
    begin
      if (!strap_ff && dose_bad)
        dose_ff <= 1'b1; // R6 R7 R9
      if (r5 || r12)
        rail_ff <= 1'b1; // R10
      // Init not confirmed after lamp test, or unreported fault
      if (!strap_ff && phase_ff == GFS_RUN
          && (!ctrl_ff[`GFS_CTRL_INIT_OK] || ctrl_ff[`GFS_CTRL_SWFAULT]))
        integ_ff <= 1'b1; // R8
    end
  end
  assign fault = dose_ff | rail_ff | integ_ff;
  // Closes valves in the same cycle that the dose error is seen, not one later
  logic trip_now;
  assign trip_now = fault | (!strap_ff & dose_bad); // R6

  // Solenoid power and valve drive
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      solenoid_power <= 1'b0;
      solenoid_on    <= '0;
    end
    else
    begin
      solenoid_power <= ctrl_ff[`GFS_CTRL_PWR] && !trip_now && controller_run; // R4
      // Bit n weights 0.5 * 2^n LPM
      solenoid_on    <= (trip_now || !ctrl_ff[`GFS_CTRL_PWR]) ? 5'h00 : flow_ff; // R1 R2 R20 R6
    end
  end

  // Panel change detection and beep timer
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sw_prev_ff <= '0;
      beep_ff    <= '0;
    end
    else
    begin
      sw_prev_ff <= sw_s;
      if (sw_s != sw_prev_ff)
        beep_ff <= 32'(BEEP_CYC); // R3
      else if (beep_ff != 32'h0)
        beep_ff <= beep_ff - 32'h1;
    end
  end

  // Error flash blink divider
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      flash_ff    <= '0;
      flash_ph_ff <= 1'b0;
    end
    else if (flash_ff == 32'(FLSH_CYC - 1))
    begin
      flash_ff    <= '0;
      flash_ph_ff <= ~flash_ph_ff;
    end
    else
      flash_ff <= flash_ff + 32'h1;
  end

  // Panel and alarm outputs
  logic lamp;
  assign lamp = (phase_ff == GFS_LAMP);
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      audio_enable <= 1'b0;
      error_flash  <= 1'b0;
      led_n        <= 4'hf;
      segment_data <= '0;
      bar_tank1    <= '0;
      bar_tank2    <= '0;
      bar_setpoint <= '0;
      esu_cut      <= 1'b0;
      esu_coag     <= 1'b0;
    end
    else
    begin
      audio_enable <= fault || (beep_ff != 32'h0); // R3 R6
      error_flash  <= fault && flash_ph_ff;        // R6
      led_n        <= lamp ? 4'h0 : ledlat_ff;     // R15 R19
      segment_data <= lamp ? 8'hff : seg_ff;       // R17
      bar_setpoint <= lamp ? 8'hff : bar_ff;       // R17
      // Bars shown outside the lamp test only with transducer present, halved for small tanks
      bar_tank1 <= lamp ? 8'hff : !tdet[0] ? 8'h00
                   : (scale_ff ? tank1_ff : {1'b0, tank1_ff[7:1]}); // R11 R12 R13
      bar_tank2 <= lamp ? 8'hff : !tdet[1] ? 8'h00
                   : (scale_ff ? tank2_ff : {1'b0, tank2_ff[7:1]}); // R11 R12 R13
      // Activation passes to the generator when enabled and fault free
      esu_cut  <= cut_s && ctrl_ff[`GFS_CTRL_ESU_CUT] && !fault;  // R18
      esu_coag <= coag_s && ctrl_ff[`GFS_CTRL_ESU_CO] && !fault;  // R18
    end
  end

  // Read data mux
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      avs_readdata <= '0;
      avs_response <= 2'b00;
    end
    else if (req)
    begin
      avs_response <= 2'b00;
      unique case (avs_address)
        `GFS_REG_CTRL:     avs_readdata <= {27'h0, ctrl_ff};
        `GFS_REG_FLOW:     avs_readdata <= {27'h0, flow_ff};
        `GFS_REG_STATUS:   avs_readdata <= {23'h0, solenoid_power, tdet, phase_ff == GFS_RUN,
                                            scale_ff, strap_ff, integ_ff, rail_ff, dose_ff};
        `GFS_REG_LEDLAT:   avs_readdata <= {28'h0, ledlat_ff};
        `GFS_REG_PANEL:    avs_readdata <= {24'h0, sw_s}; // R16
        `GFS_REG_TANK1:    avs_readdata <= {24'h0, tank1_ff};
        `GFS_REG_TANK2:    avs_readdata <= {24'h0, tank2_ff};
        `GFS_REG_SEG:      avs_readdata <= {24'h0, seg_ff};
        `GFS_REG_BAR:      avs_readdata <= {24'h0, bar_ff};
        `GFS_REG_ADC_SEL:  avs_readdata <= {29'h0, adcsel_ff};
        `GFS_REG_ADC_DATA: avs_readdata <= {20'h0, adcdat_ff}; // R14
        `GFS_REG_LIMITS:   avs_readdata <= {16'h0, lim_hi_ff, lim_lo_ff};
        default:
        begin
          avs_readdata <= '0;
          avs_response <= 2'b10;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: dv/gfs_chk.sv
// Port assertions for the gas flow supervisor
`timescale 1ns/1ps
`default_nettype none
module gfs_chk #(
  parameter int POR_CYC  = 4,
  parameter int LAMP_CYC = 20
) (
  // Clock, reset and bus
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  // Pins and outputs
  input wire logic        rail5_fault,
  input wire logic [1:0]  tank_detect,
  input wire logic [7:0]  panel_switches,
  input wire logic        act_cut,
  input wire logic [4:0]  solenoid_on,
  input wire logic        solenoid_power,
  input wire logic        audio_enable,
  input wire logic        esu_cut,
  input wire logic        controller_run,
  input wire logic [3:0]  led_n,
  input wire logic [7:0]  segment_data,
  input wire logic [7:0]  bar_tank1
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Cycles since reset release, cycles since run began
  logic [15:0] up_ff;
  logic [15:0] run_ff;
  always_ff @(posedge core_clk)
  begin
    up_ff  <= rst ? 16'h0 : up_ff + 16'h1;
    run_ff <= (rst || !controller_run) ? 16'h0 : run_ff + 16'h1;
  end
  a_hold_min: assert property (controller_run |-> up_ff >= POR_CYC - 1)
    else $error("controller released too early");
  a_hold_max: assert property (up_ff == POR_CYC + 3 |-> controller_run)
    else $error("controller held too long");
  a_lamp_test: assert property (run_ff >= 2 && run_ff <= LAMP_CYC - 2
    |-> led_n == 4'h0 && segment_data == 8'hff) else $error("lamp test dark");
  a_tank_bar: assert property ((!tank_detect[0] && run_ff > LAMP_CYC + 3)[*5]
    |-> bar_tank1 == 8'h00) else $error("bar lit without transducer");
  a_panel_beep: assert property ($changed(panel_switches) && run_ff > LAMP_CYC + 3
    |-> ##[1:6] audio_enable) else $error("no beep on panel change");
  a_cut_cause: assert property ((!act_cut)[*5] |=> !esu_cut)
    else $error("cut without activation");
  a_rail_close: assert property (rail5_fault && controller_run
    |-> ##[1:6] (!solenoid_power && solenoid_on == 5'h00)) else $error("rail trip open");
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus answer late");
  a_unmapped_rd: assert property (avs_read && !avs_waitrequest && avs_address == 8'h30
    |-> avs_response == 2'b10 && avs_readdata == 32'h0) else $error("unmapped read");
endmodule
bind gfs_top gfs_chk #(.POR_CYC(POR_CYC), .LAMP_CYC(LAMP_CYC)) u_chk (
  .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .rail5_fault(rail5_fault), .tank_detect(tank_detect),
  .panel_switches(panel_switches), .act_cut(act_cut), .solenoid_on(solenoid_on),
  .solenoid_power(solenoid_power), .audio_enable(audio_enable), .esu_cut(esu_cut),
  .controller_run(controller_run), .led_n(led_n), .segment_data(segment_data),
  .bar_tank1(bar_tank1));
`default_nettype wire

// file: dv/gfs_far.sv
// Far-side model: converter and solenoid bank
`timescale 1ns/1ps
`default_nettype none
module gfs_far (
  // Clock
  input  wire logic        core_clk,
  // Converter
  input  wire logic [2:0]  adc_channel,
  output var  logic [11:0] adc_sample,
  output var  logic        adc_valid,
  // Solenoid bank and resulting flow in half litres
  input  wire logic [4:0]  solenoid_on,
  input  wire logic        solenoid_power,
  output var  logic [5:0]  flow_half
);
  logic [2:0] tick_ff;
  initial
  begin
    tick_ff = 3'h0;
    adc_sample = 12'h0;
    adc_valid = 1'b0;
  end
  // One conversion every eight cycles, sample garbled between pulses
  always @(posedge core_clk)
  begin
    tick_ff <= tick_ff + 3'h1;
    adc_valid <= (tick_ff == 3'h7);
    adc_sample <= (tick_ff == 3'h7) ? {9'h0a5, adc_channel} : ~adc_sample;
  end
  // Weights 0.5, 1, 2, 4, 8 sum to the mask in half litres
  assign flow_half = solenoid_power ? {1'b0, solenoid_on} : 6'h00;
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the gas flow supervisor
`timescale 1ns/1ps
`default_nettype none
`include "gfs_map.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module tb_top;
  localparam int LC = 20;
  logic        core_clk = 1'b0;
  logic        rst, avs_read, avs_write, sup_off, scale, rail5, act_cut, act_coag;
  logic [7:0]  avs_address, panel;
  logic [31:0] avs_writedata, q;
  logic [1:0]  tank_detect;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, adc_valid, solenoid_power, audio_enable, esu_cut;
  logic        esu_coag, controller_run, error_flash, seen;
  logic [1:0]  avs_response;
  logic [11:0] adc_sample;
  logic [2:0]  adc_channel;
  logic [4:0]  solenoid_on;
  logic [5:0]  flow_half;
  logic [3:0]  led_n;
  logic [7:0]  segment_data, bar_tank1, bar_tank2, bar_setpoint;
  logic [10:0] rows [7] = '{{5'h01, 6'h01}, {5'h02, 6'h02}, {5'h04, 6'h04},
    {5'h08, 6'h08}, {5'h10, 6'h10}, {5'h1f, 6'h1f}, {5'h00, 6'h00}};
  int          fails = 0;
  int          total_checks = 0;
  int          cyc = 0;
  always #25 core_clk = ~core_clk;
  gfs_top #(.POR_CYC(4), .LAMP_CYC(LC), .BEEP_CYC(5), .FLSH_CYC(3)) u_dut (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .supervisor_disable_strap(sup_off),
    .tank_scale_strap(scale), .rail5_fault(rail5), .rail12_fault(1'b0),
    .tank_detect(tank_detect), .panel_switches(panel), .act_cut(act_cut),
    .act_coag(act_coag), .adc_sample(adc_sample), .adc_valid(adc_valid),
    .adc_channel(adc_channel), .solenoid_on(solenoid_on), .solenoid_power(solenoid_power),
    .audio_enable(audio_enable), .esu_cut(esu_cut), .esu_coag(esu_coag),
    .controller_run(controller_run), .led_n(led_n), .segment_data(segment_data),
    .bar_tank1(bar_tank1), .bar_tank2(bar_tank2), .bar_setpoint(bar_setpoint),
    .error_flash(error_flash));
  gfs_far u_far (.core_clk(core_clk), .adc_channel(adc_channel), .adc_sample(adc_sample),
    .adc_valid(adc_valid), .solenoid_on(solenoid_on), .solenoid_power(solenoid_power),
    .flow_half(flow_half));
  // Prints the counts and the verdict, then ends the run
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One bus access, held until waitrequest is sampled low; only the hang guard ends a wait
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  // Power cycle, limits written during hold, control written during lamp test, then run
  task automatic bring_up();
    int n = 0;
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    `CHK(controller_run, 1'b0)
    xfer(1'b1, `GFS_REG_LIMITS, 32'h1f00);
    xfer(1'b1, `GFS_REG_CTRL, 32'h0f);
    while (controller_run !== 1'b1 && n < 100)
    begin
      @(posedge core_clk);
      n++;
    end
    repeat (3) @(posedge core_clk);
    `CHK(led_n, 4'h0)
    repeat (LC) @(posedge core_clk);
  endtask
  // Hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      stop_test();
    end
  end
  initial
  begin
    {rst, avs_read, avs_write, sup_off, scale, rail5, act_cut, act_coag} = 8'h81;
    {avs_address, panel, avs_writedata, tank_detect} = {16'h0, 32'h0, 2'h3};
    bring_up();
    for (int i = 0; i < 7; i++)
    begin
      xfer(1'b1, `GFS_REG_FLOW, {27'h0, rows[i][10:6]});
      repeat (3) @(posedge core_clk);
      `CHK(solenoid_on, rows[i][10:6])
      `CHK(flow_half, rows[i][5:0])
    end
    panel <= 8'h5a;
    repeat (5) @(posedge core_clk);
    `CHK(audio_enable, 1'b1)
    xfer(1'b0, `GFS_REG_PANEL, 32'h0);
    `CHK(q[7:0], 8'h5a)
    xfer(1'b1, `GFS_REG_LEDLAT, 32'ha);
    xfer(1'b1, `GFS_REG_SEG, 32'h3c);
    xfer(1'b1, `GFS_REG_BAR, 32'hc3);
    xfer(1'b1, `GFS_REG_TANK2, 32'h80);
    @(posedge core_clk);
    `CHK(led_n, 4'ha)
    // Scale strap was low at power-up, so the tank bar shows half the value
    `CHK({segment_data, bar_setpoint, bar_tank2}, 24'h3cc340)
    scale <= 1'b0;
    act_cut <= 1'b1;
    act_coag <= 1'b1;
    tank_detect <= 2'b10;
    repeat (8) @(posedge core_clk);
    `CHK(bar_tank2, 8'h40)
    `CHK({esu_cut, esu_coag}, 2'b11)
    `CHK(bar_tank1, 8'h00)
    xfer(1'b1, `GFS_REG_ADC_SEL, 32'h3);
    repeat (20) @(posedge core_clk);
    xfer(1'b0, `GFS_REG_ADC_DATA, 32'h0);
    `CHK(q[11:0], 12'h52b)
    xfer(1'b0, `GFS_REG_STATUS, 32'h0);
    `CHK(q[7:6], 2'b10)
    `CHK(q[2], 1'b0)
    xfer(1'b0, 8'h30, 32'h0);
    `CHK({q, avs_response}, 34'h2)
    xfer(1'b1, `GFS_REG_LIMITS, 32'h0400);
    xfer(1'b1, `GFS_REG_FLOW, 32'h10);
    seen = 1'b0;
    repeat (8)
    begin
      @(posedge core_clk);
      seen = seen | error_flash;
    end
    `CHK({seen, audio_enable, solenoid_power, solenoid_on}, 8'hc0)
    xfer(1'b1, `GFS_REG_FLOW, 32'h1);
    repeat (3) @(posedge core_clk);
    `CHK(solenoid_on, 5'h00)
    xfer(1'b0, `GFS_REG_STATUS, 32'h0);
    `CHK(q[0], 1'b1)
    xfer(1'b1, `GFS_REG_CTRL, 32'h1f);
    xfer(1'b0, `GFS_REG_STATUS, 32'h0);
    `CHK(q[2], 1'b1)
    sup_off <= 1'b1;
    scale <= 1'b1;
    bring_up();
    xfer(1'b1, `GFS_REG_TANK2, 32'h80);
    @(posedge core_clk);
    `CHK(bar_tank2, 8'h80)
    xfer(1'b1, `GFS_REG_LIMITS, 32'h0400);
    xfer(1'b1, `GFS_REG_FLOW, 32'h10);
    repeat (8) @(posedge core_clk);
    `CHK(solenoid_on, 5'h10)
    xfer(1'b0, `GFS_REG_STATUS, 32'h0);
    `CHK({q[3], q[0]}, 2'b10)
    rail5 <= 1'b1;
    repeat (3) @(posedge core_clk);
    rail5 <= 1'b0;
    repeat (6) @(posedge core_clk);
    xfer(1'b0, `GFS_REG_STATUS, 32'h0);
    `CHK({q[1], solenoid_power}, 2'b10)
    stop_test();
  end
endmodule
`default_nettype wire
